// *** core/async_timer.sv ***
// Clock-domain control, holding registers and waveform core of an 8-bit timer.
// Assumes the oscillator input is sampled on clk and clk is over four times its rate.
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
module async_timer #(
  parameter int PRESC_W = 10
) (
  // System
  input  wire logic                      clk,
  input  wire logic                      reset,
  // APB slave
  input  wire async_timer_pkg::apb_req_t apb_req,
  output logic [31:0]                    prdata,
  output logic                           pready,
  output logic                           pslverr,
  // Oscillator and pins
  input  wire logic                      timer_osc_in,
  input  wire async_timer_pkg::sleep_t   sleep_state,
  output logic                           compare_output_pin,
  output logic                           osc_port_released,
  output logic                           crystal_osc_run,
  output logic                           ext_clock_buf_en,
  // Interrupt requests and wake
  output logic                           compare_irq,
  output logic                           overflow_irq,
  output logic                           wake_request
);
  import async_timer_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic                 pready;
    logic                 pslverr;
    logic [31:0]          prdata;
    logic                 osc_s1;
    logic                 osc_s2;
    logic                 osc_s3;
    logic                 async_clock_select;
    logic                 ext_clock_input_en;
    logic [2:0]           busy;
    logic [2:0][1:0]      edge_cnt;
    logic [2:0][7:0]      hold;
    logic [7:0]           counter_value;
    logic [7:0]           compare_value_a;
    logic [7:0]           compare_active;
    logic [7:0]           timer_control_a;
    logic                 count_down;
    logic [PRESC_W-1:0]   presc;
    logic                 block_match;
    logic [7:0]           counter_copy;
    logic [FLAG_SYNC-1:0] cmp_pipe;
    logic [FLAG_SYNC-1:0] ovf_pipe;
    logic                 compare_flag;
    logic                 overflow_flag;
    logic                 compare_irq_enable;
    logic                 overflow_irq_enable;
    logic                 oc_pin;
    logic                 irq_cmp;
    logic                 irq_ovf;
    logic                 cond_seen;
    logic                 wake;
    logic                 armed;
    logic                 osc_run;
    logic                 port_off;
    logic                 ext_buf;
  } state_t;

  state_t s_q;
  state_t s_d;

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    logic               setup;
    logic               wr;
    logic [9:0]         idx;
    logic               hit;
    logic [7:0]         wd;
    logic               osc_rise;
    logic               src_tick;
    logic               tick;
    logic [PRESC_W-1:0] mask;
    logic [2:0]         commit;
    logic               ctl_new;
    logic [7:0]         ctl_val;
    logic               cnt_new;
    logic [7:0]         cnt_val;
    logic               cmp_new;
    logic [7:0]         cmp_val;
    logic               match;
    logic               cmp_ev;
    logic               ovf_ev;
    logic               bottom;
    logic               top_hit;
    logic               force_now;
    logic               set_cmp;
    logic               set_ovf;
    logic [1:0]         com;
    wave_mode_t         mode;
    s_d       = s_q;
    setup     = apb_req.psel & ~apb_req.penable;
    wr        = apb_req.psel & apb_req.penable & apb_req.pwrite & s_q.pready;
    idx       = apb_req.paddr[11:2];
    wd        = apb_req.pwdata[7:0];
    hit       = 1'b0;
    commit    = 3'b000;
    ctl_new   = 1'b0;
    ctl_val   = s_q.timer_control_a;
    cnt_new   = 1'b0;
    cnt_val   = s_q.counter_value;
    cmp_new   = 1'b0;
    cmp_val   = s_q.compare_value_a;
    mask      = '0;
    tick      = 1'b0;
    match     = 1'b0;
    cmp_ev    = 1'b0;
    ovf_ev    = 1'b0;
    bottom    = 1'b0;
    top_hit   = 1'b0;
    force_now = 1'b0;
    com       = s_q.timer_control_a[CTL_COM_HI:CTL_COM_LO];
    mode      = wave_mode_t'({s_q.timer_control_a[CTL_WGM_HI], s_q.timer_control_a[CTL_WGM_LO]});
    set_cmp   = 1'b0;
    set_ovf   = 1'b0;
    osc_rise  = s_q.osc_s2 & ~s_q.osc_s3;
    src_tick  = s_q.async_clock_select ? osc_rise : 1'b1;

    // APB: zero-wait answer, read data captured in the setup cycle.
    s_d.pready  = setup;
    s_d.pslverr = 1'b0;
    if (setup) begin
      s_d.prdata = 32'h0000_0000;
      hit        = 1'b1;
      if (idx == IDX_CONTROL) begin
        s_d.prdata[7:0] = {1'b0, s_q.timer_control_a[6:0]};
      end else if (idx == IDX_COUNTER) begin
        s_d.prdata[7:0] = s_q.counter_copy;
      end else if (idx == IDX_COMPARE) begin
        s_d.prdata[7:0] = s_q.compare_value_a;
      end else if (idx == IDX_IRQ_EN) begin
        s_d.prdata[IRQ_CMP] = s_q.compare_irq_enable;
        s_d.prdata[IRQ_OVF] = s_q.overflow_irq_enable;
      end else if (idx == IDX_FLAGS) begin
        s_d.prdata[IRQ_CMP] = s_q.compare_flag;
        s_d.prdata[IRQ_OVF] = s_q.overflow_flag;
      end else if (idx == IDX_STATUS) begin
        s_d.prdata[ST_EXT]   = s_q.ext_clock_input_en;
        s_d.prdata[ST_ASYNC] = s_q.async_clock_select;
        s_d.prdata[2:0]      = s_q.busy;
      end else begin
        hit = 1'b0;
      end
      s_d.pslverr = ~hit;
    end

    // Oscillator input: two synchronizing stages, then an edge stage.
    s_d.osc_s1 = timer_osc_in;
    s_d.osc_s2 = s_q.osc_s1;
    s_d.osc_s3 = s_q.osc_s2;

    // Holding registers finish after the second rising oscillator edge.
    for (int i = 0; i < 3; i++) begin
      if (s_q.busy[i] && osc_rise) begin
        if (s_q.edge_cnt[i] == XFER_EDGES - 2'h1) begin
          commit[i]   = 1'b1;
          s_d.busy[i] = 1'b0;
        end else begin
          s_d.edge_cnt[i] = s_q.edge_cnt[i] + 2'h1;
        end
      end
    end
    if (commit[SLOT_CTL]) begin
      ctl_new = 1'b1;
      ctl_val = s_q.hold[SLOT_CTL];
    end
    if (commit[SLOT_CMP]) begin
      cmp_new = 1'b1;
      cmp_val = s_q.hold[SLOT_CMP];
    end
    if (commit[SLOT_COUNT]) begin
      cnt_new = 1'b1;
      cnt_val = s_q.hold[SLOT_COUNT];
    end

    // Register writes; async writes go to their own holding slot.
    if (wr) begin
      if (idx == IDX_CONTROL || idx == IDX_COMPARE || idx == IDX_COUNTER) begin
        if (s_q.async_clock_select) begin
          if (idx == IDX_CONTROL) begin
            s_d.hold[SLOT_CTL]     = wd;
            s_d.busy[SLOT_CTL]     = 1'b1;
            s_d.edge_cnt[SLOT_CTL] = 2'h0;
          end else if (idx == IDX_COMPARE) begin
            s_d.hold[SLOT_CMP]     = wd;
            s_d.busy[SLOT_CMP]     = 1'b1;
            s_d.edge_cnt[SLOT_CMP] = 2'h0;
          end else begin
            s_d.hold[SLOT_COUNT]     = wd;
            s_d.busy[SLOT_COUNT]     = 1'b1;
            s_d.edge_cnt[SLOT_COUNT] = 2'h0;
          end
        end else if (idx == IDX_CONTROL) begin
          ctl_new = 1'b1;
          ctl_val = wd;
        end else if (idx == IDX_COMPARE) begin
          cmp_new = 1'b1;
          cmp_val = wd;
        end else begin
          cnt_new = 1'b1;
          cnt_val = wd;
        end
      end else if (idx == IDX_IRQ_EN) begin
        s_d.compare_irq_enable  = wd[IRQ_CMP];
        s_d.overflow_irq_enable = wd[IRQ_OVF];
      end else if (idx == IDX_STATUS) begin
        s_d.ext_clock_input_en = wd[ST_EXT];
        s_d.async_clock_select = wd[ST_ASYNC];
      end
    end

    // Prescaler taps on the selected source clock.
    case (clock_sel_t'(s_q.timer_control_a[CTL_CS_HI:0]))
      CS_DIV8:    mask = PRESC_W'(10'h007);
      CS_DIV32:   mask = PRESC_W'(10'h01f);
      CS_DIV64:   mask = PRESC_W'(10'h03f);
      CS_DIV128:  mask = PRESC_W'(10'h07f);
      CS_DIV256:  mask = PRESC_W'(10'h0ff);
      CS_DIV1024: mask = PRESC_W'(10'h3ff);
      default:    mask = '0;
    endcase
    if (s_q.timer_control_a[CTL_CS_HI:0] != CS_STOP && src_tick) begin
      s_d.presc = s_q.presc + PRESC_W'(1);
      tick      = (s_q.presc & mask) == mask;
    end

    // Compare match is held off by pending counter or compare transfers.
    match = (s_q.counter_value == s_q.compare_active) & ~s_q.block_match
          & ~s_q.busy[SLOT_COUNT] & ~s_q.busy[SLOT_CMP];

    // Counting sequence per waveform mode.
    if (tick) begin
      s_d.block_match = 1'b0;
      cmp_ev          = match;
      case (mode)
        MODE_PHASE: begin
          if (!s_q.count_down && s_q.counter_value == COUNT_MAX) begin
            s_d.count_down    = 1'b1;
            s_d.counter_value = s_q.counter_value - 8'h01;
            top_hit           = 1'b1;
          end else if (s_q.count_down && s_q.counter_value == 8'h00) begin
            s_d.count_down    = 1'b0;
            s_d.counter_value = 8'h01;
            ovf_ev            = 1'b1;
          end else if (s_q.count_down) begin
            s_d.counter_value = s_q.counter_value - 8'h01;
          end else begin
            s_d.counter_value = s_q.counter_value + 8'h01;
          end
        end
        MODE_CLEAR: begin
          s_d.count_down    = 1'b0;
          ovf_ev            = s_q.counter_value == COUNT_MAX;
          s_d.counter_value = match ? 8'h00 : s_q.counter_value + 8'h01;
        end
        default: begin
          s_d.count_down    = 1'b0;
          ovf_ev            = s_q.counter_value == COUNT_MAX;
          bottom            = ovf_ev;
          s_d.counter_value = s_q.counter_value + 8'h01;
        end
      endcase

      // Output pin moves on the timer tick, not on a synchronized copy.
      if (mode == MODE_FAST) begin
        if (match && com[1]) begin
          s_d.oc_pin = com[0];
        end else if (bottom && com[1]) begin
          s_d.oc_pin = ~com[0];
        end
      end else if (mode == MODE_PHASE) begin
        if (match && com[1]) begin
          s_d.oc_pin = com[0] ^ s_q.count_down;
        end
      end else if (match) begin
        case (com)
          2'b01:   s_d.oc_pin = ~s_q.oc_pin;
          2'b10:   s_d.oc_pin = 1'b0;
          2'b11:   s_d.oc_pin = 1'b1;
          default: s_d.oc_pin = s_q.oc_pin;
        endcase
      end
    end

    // Double-buffered compare value in the PWM modes.
    if (mode == MODE_NORMAL || mode == MODE_CLEAR || (mode == MODE_PHASE && top_hit)
        || (mode == MODE_FAST && bottom)) begin
      s_d.compare_active = s_q.compare_value_a;
    end

    // Register updates take priority over counting in the same cycle.
    if (cnt_new) begin
      s_d.counter_value = cnt_val;
      s_d.block_match   = 1'b1;
    end
    if (cmp_new) begin
      s_d.compare_value_a = cmp_val;
    end
    if (ctl_new) begin
      s_d.timer_control_a = {1'b0, ctl_val[6:0]};
      force_now = ctl_val[CTL_FORCE] & ~ctl_val[CTL_WGM_LO];
    end
    // A forced match only drives the pin: no flag, no counter clear.
    if (force_now) begin
      case (ctl_val[CTL_COM_HI:CTL_COM_LO])
        2'b01:   s_d.oc_pin = ~s_q.oc_pin;
        2'b10:   s_d.oc_pin = 1'b0;
        2'b11:   s_d.oc_pin = 1'b1;
        default: s_d.oc_pin = s_q.oc_pin;
      endcase
    end

    // Readable counter copy follows the oscillator edges in async mode.
    if (!s_q.async_clock_select || osc_rise) begin
      s_d.counter_copy = s_q.counter_value;
    end

    // Async events reach the flags three system cycles later than synchronous ones.
    s_d.cmp_pipe = {s_q.cmp_pipe[FLAG_SYNC-2:0], cmp_ev & s_q.async_clock_select};
    s_d.ovf_pipe = {s_q.ovf_pipe[FLAG_SYNC-2:0], ovf_ev & s_q.async_clock_select};
    set_cmp = s_q.async_clock_select ? s_q.cmp_pipe[FLAG_SYNC-1] : cmp_ev;
    set_ovf = s_q.async_clock_select ? s_q.ovf_pipe[FLAG_SYNC-1] : ovf_ev;
    if (wr && idx == IDX_FLAGS) begin
      s_d.compare_flag  = s_q.compare_flag & ~wd[IRQ_CMP];
      s_d.overflow_flag = s_q.overflow_flag & ~wd[IRQ_OVF];
    end
    if (set_cmp) begin
      s_d.compare_flag = 1'b1;
    end
    if (set_ovf) begin
      s_d.overflow_flag = 1'b1;
    end
    s_d.irq_cmp = s_q.compare_flag & s_q.compare_irq_enable;
    s_d.irq_ovf = s_q.overflow_flag & s_q.overflow_irq_enable;

    // Wake: start on the timer cycle after the condition, rearm on the timer cycle after wake drops.
    s_d.cond_seen = s_q.irq_cmp | s_q.irq_ovf;
    if (!sleep_state.power_save) begin
      s_d.wake = 1'b0;
    end else if (s_q.armed && s_q.cond_seen && src_tick) begin
      s_d.wake  = 1'b1;
      s_d.armed = 1'b0;
    end
    if (!s_q.armed && !s_q.wake && src_tick) begin
      s_d.armed = 1'b1;
    end

    // Oscillator and pin control.
    s_d.port_off = s_q.async_clock_select;
    s_d.osc_run  = s_q.async_clock_select & ~s_q.ext_clock_input_en
                 & ~sleep_state.deep_sleep;
    s_d.ext_buf  = s_q.async_clock_select & s_q.ext_clock_input_en
                 & ~sleep_state.deep_sleep;
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      s_q                 <= '0;
      s_q.timer_control_a <= RESET_VALUE;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata             = s_q.prdata;
  assign pready             = s_q.pready;
  assign pslverr            = s_q.pslverr;
  assign compare_output_pin = s_q.oc_pin;
  assign osc_port_released  = s_q.port_off;
  assign crystal_osc_run    = s_q.osc_run;
  assign ext_clock_buf_en   = s_q.ext_buf;
  assign compare_irq        = s_q.irq_cmp;
  assign overflow_irq       = s_q.irq_ovf;
  assign wake_request       = s_q.wake;

endmodule : async_timer

// *** core/async_timer_pkg.sv ***
// Constants, field layouts and carrier types of the asynchronous timer block.
// Assumes an APB master with 32-bit data and one synchronous, active-high reset.
package async_timer_pkg;

  // Register indices; byte address is four times the index.
  localparam logic [9:0] IDX_CONTROL = 10'h0b0;
  localparam logic [9:0] IDX_COUNTER = 10'h0b1;
  localparam logic [9:0] IDX_COMPARE = 10'h0b2;
  localparam logic [9:0] IDX_IRQ_EN  = 10'h0b3;
  localparam logic [9:0] IDX_FLAGS   = 10'h0b4;
  localparam logic [9:0] IDX_STATUS  = 10'h0b6;
  localparam logic [7:0] RESET_VALUE = 8'h00;

  // Control register fields.
  localparam int CTL_FORCE   = 7;
  localparam int CTL_WGM_LO  = 6;
  localparam int CTL_COM_HI  = 5;
  localparam int CTL_COM_LO  = 4;
  localparam int CTL_WGM_HI  = 3;
  localparam int CTL_CS_HI   = 2;
  // Status register fields; busy bit index equals holding slot index.
  localparam int ST_EXT      = 4;
  localparam int ST_ASYNC    = 3;
  localparam int SLOT_COUNT  = 2;
  localparam int SLOT_CMP    = 1;
  localparam int SLOT_CTL    = 0;
  // Interrupt enable and flag fields.
  localparam int IRQ_CMP     = 1;
  localparam int IRQ_OVF     = 0;

  localparam logic [1:0] XFER_EDGES = 2'h2;
  localparam int         FLAG_SYNC  = 3;
  localparam logic [7:0] COUNT_MAX  = 8'hff;

  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_PHASE  = 2'b01,
    MODE_CLEAR  = 2'b10,
    MODE_FAST   = 2'b11
  } wave_mode_t;

  typedef enum logic [2:0] {
    CS_STOP = 3'b000, CS_DIV1 = 3'b001, CS_DIV8 = 3'b010, CS_DIV32 = 3'b011,
    CS_DIV64 = 3'b100, CS_DIV128 = 3'b101, CS_DIV256 = 3'b110, CS_DIV1024 = 3'b111
  } clock_sel_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic        power_save;
    logic        deep_sleep;
  } sleep_t;

endpackage : async_timer_pkg

// *** verif/async_timer_chk.sv ***
// Port checker for the asynchronous timer block.
// Assumes it is bound onto every async_timer instance.
`timescale 1ns/1ps
module async_timer_chk #(
  parameter int PRESC_W = 10
) (
  input wire logic                      clk,
  input wire logic                      reset,
  input wire async_timer_pkg::apb_req_t apb_req,
  input wire logic [31:0]               prdata,
  input wire logic                      pready,
  input wire logic                      pslverr,
  input wire logic                      timer_osc_in,
  input wire async_timer_pkg::sleep_t   sleep_state,
  input wire logic                      compare_output_pin,
  input wire logic                      osc_port_released,
  input wire logic                      crystal_osc_run,
  input wire logic                      ext_clock_buf_en,
  input wire logic                      compare_irq,
  input wire logic                      overflow_irq,
  input wire logic                      wake_request
);
  import async_timer_pkg::*;
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  wire acc = apb_req.psel & apb_req.penable & pready;
  wire rd  = acc & !apb_req.pwrite;
  wire [11:0] a = apb_req.paddr;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_zero_wait: assert property (apb_req.psel & !apb_req.penable |=> pready)
    else $error("no answer after setup");
  a_err_read_zero: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error answer malformed");
  a_force_reads_0: assert property (rd && a == {IDX_CONTROL, 2'b00} |-> prdata[31:7] == 25'h0)
    else $error("force bit read back");
  a_status_upper: assert property (rd && a == {IDX_STATUS, 2'b00} |-> prdata[31:5] == 27'h0)
    else $error("status upper bits set");
  a_async_port: assert property (acc && apb_req.pwrite && a == {IDX_STATUS, 2'b00}
    |=> ##1 osc_port_released == $past(apb_req.pwdata[ST_ASYNC], 2))
    else $error("port release mismatch");
  a_deep_stops: assert property (sleep_state.deep_sleep[*2] |=> !crystal_osc_run && !ext_clock_buf_en)
    else $error("oscillator runs in deep sleep");
  a_ext_needs_async: assert property (ext_clock_buf_en |-> osc_port_released)
    else $error("external buffer without async");
  a_xtal_or_ext: assert property (!(crystal_osc_run && ext_clock_buf_en))
    else $error("crystal and external both on");
  a_wake_drops: assert property (!sleep_state.power_save |=> !wake_request)
    else $error("wake without sleep");
  cover property (acc && pslverr);
  cover property (ext_clock_buf_en);
  cover property (crystal_osc_run);
  cover property (wake_request);
endmodule : async_timer_chk

bind async_timer async_timer_chk #(.PRESC_W(PRESC_W)) u_chk (
  .clk(clk), .reset(reset), .apb_req(apb_req), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .timer_osc_in(timer_osc_in), .sleep_state(sleep_state),
  .compare_output_pin(compare_output_pin), .osc_port_released(osc_port_released),
  .crystal_osc_run(crystal_osc_run), .ext_clock_buf_en(ext_clock_buf_en),
  .compare_irq(compare_irq), .overflow_irq(overflow_irq), .wake_request(wake_request)
);

// *** verif/async_timer_bench.sv ***
// Self-checking bench for the asynchronous timer block.
// Assumes the checker file is compiled with it.
`timescale 1ns/1ps
module async_timer_bench;
  import async_timer_pkg::*;
  // ----------------------------------------
  // Stimulus and checks
  // ----------------------------------------
  logic        clk = 1'b0, reset = 1'b1, osc = 1'b0, er, cur;
  apb_req_t    req = '0;
  sleep_t      slp = '0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, pin, port_rel, xtal, ext_buf, cirq, oirq, wake;
  logic [7:0]  d;
  logic [9:0]  regs [6] = '{IDX_CONTROL, IDX_COUNTER, IDX_COMPARE, IDX_IRQ_EN, IDX_FLAGS, IDX_STATUS};
  logic [7:0]  fv [3] = '{8'hb8, 8'ha0, 8'h98};
  int          num_errors = 0, n_tests = 0, cyc = 0, seed = 61, i;

  async_timer #(.PRESC_W(10)) DUT (
    .clk(clk), .reset(reset), .apb_req(req), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_osc_in(osc), .sleep_state(slp), .compare_output_pin(pin),
    .osc_port_released(port_rel), .crystal_osc_run(xtal), .ext_clock_buf_en(ext_buf),
    .compare_irq(cirq), .overflow_irq(oirq), .wake_request(wake));

  always #5 clk = ~clk;

  task tally_and_finish;
    if (num_errors == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : tally_and_finish

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors = num_errors + 1;
      tally_and_finish();
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task xfer(input logic w, input logic [9:0] idx, input logic [31:0] wd);
    @(posedge clk);
    req <= '{1'b1, 1'b0, w, {idx, 2'b00}, wd};
    @(posedge clk);
    req.penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : xfer

  task rdc(input logic [9:0] idx, input logic [31:0] exp);
    xfer(1'b0, idx, 32'h0);
    chk(rd, exp);
  endtask : rdc

  // The oscillator stays at four times slower than clk or more.
  task pulse;
    osc <= 1'b1;
    repeat (5) @(posedge clk);
    osc <= 1'b0;
    repeat (5) @(posedge clk);
  endtask : pulse

  function logic force_pin(input logic [1:0] com, input logic c);
    case (com)
      2'h1:    return !c;
      2'h2:    return 1'b0;
      2'h3:    return 1'b1;
      default: return c;
    endcase
  endfunction : force_pin

  initial begin
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    for (i = 0; i < 6; i++) rdc(regs[i], 32'h0);
    xfer(1'b0, 10'h0b7, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    for (i = 0; i < 8; i++) begin
      d = 8'($random(seed));
      if (d[6]) d[7] = 1'b0;
      xfer(1'b1, IDX_CONTROL, {24'h0, d});
      rdc(IDX_CONTROL, {25'h0, d[6:0]});
      rdc(IDX_STATUS, 32'h0);
    end
    xfer(1'b1, IDX_CONTROL, 32'h30);
    xfer(1'b1, IDX_COUNTER, 32'h77);
    xfer(1'b1, IDX_FLAGS, 32'h3);
    cur = 1'b0;
    for (i = 0; i < 3; i++) begin
      xfer(1'b1, IDX_CONTROL, {24'h0, fv[i]});
      repeat (2) @(posedge clk);
      cur = force_pin(fv[i][5:4], cur);
      chk({31'h0, pin}, {31'h0, cur});
    end
    rdc(IDX_FLAGS, 32'h0);
    rdc(IDX_COUNTER, 32'h77);
    xfer(1'b1, IDX_COMPARE, 32'h05);
    xfer(1'b1, IDX_COUNTER, 32'h00);
    xfer(1'b1, IDX_IRQ_EN, 32'h3);
    xfer(1'b1, IDX_CONTROL, 32'h01);
    // Over 256 undivided ticks pass, so the counter both matches and wraps.
    repeat (300) @(posedge clk);
    rdc(IDX_FLAGS, 32'h3);
    chk({30'h0, cirq, oirq}, 32'h3);
    slp.power_save <= 1'b1;
    repeat (3) @(posedge clk);
    chk({31'h0, wake}, 32'h1);
    slp.power_save <= 1'b0;
    repeat (2) @(posedge clk);
    chk({31'h0, wake}, 32'h0);
    xfer(1'b1, IDX_CONTROL, 32'h00);
    xfer(1'b1, IDX_FLAGS, 32'h3);
    xfer(1'b1, IDX_IRQ_EN, 32'h0);
    xfer(1'b1, IDX_COUNTER, 32'h00);
    xfer(1'b1, IDX_CONTROL, 32'h02);
    // The stop write lands 64 edges later: eight ticks at divide-by-8.
    repeat (61) @(posedge clk);
    xfer(1'b1, IDX_CONTROL, 32'h00);
    rdc(IDX_COUNTER, 32'h08);
    rdc(IDX_FLAGS, 32'h2);
    xfer(1'b1, IDX_STATUS, 32'h1f);
    rdc(IDX_STATUS, 32'h18);
    chk({29'h0, port_rel, xtal, ext_buf}, 32'h5);
    slp.deep_sleep <= 1'b1;
    repeat (3) @(posedge clk);
    chk({31'h0, ext_buf}, 32'h0);
    slp.deep_sleep <= 1'b0;
    xfer(1'b1, IDX_STATUS, 32'h08);
    repeat (2) @(posedge clk);
    chk({30'h0, xtal, ext_buf}, 32'h2);
    xfer(1'b1, IDX_COMPARE, 32'h5a);
    rdc(IDX_STATUS, 32'h0a);
    xfer(1'b1, IDX_COUNTER, 32'h3c);
    xfer(1'b1, IDX_CONTROL, 32'h20);
    rdc(IDX_STATUS, 32'h0f);
    pulse();
    rdc(IDX_STATUS, 32'h0f);
    pulse();
    rdc(IDX_STATUS, 32'h08);
    rdc(IDX_COMPARE, 32'h5a);
    rdc(IDX_CONTROL, 32'h20);
    pulse();
    rdc(IDX_COUNTER, 32'h3c);
    xfer(1'b1, IDX_STATUS, 32'h0);
    repeat (2) @(posedge clk);
    chk({31'h0, port_rel}, 32'h0);
    tally_and_finish();
  end
endmodule : async_timer_bench
